// ### rtl/adc_gpio_config_map.vh
// register map and command encodings of the pin configuration port
`ifndef ADC_GPIO_CONFIG_MAP_VH
`define ADC_GPIO_CONFIG_MAP_VH

// register address and reset value
`define PIN_CFG_ADDR        3'h4
`define PIN_CFG_RESET       7'h00

// field positions inside the pin configuration register
`define PIN_CFG_RSVD_BIT    7
`define PIN2_DIR_BIT        6
`define PIN1_DIR_BIT        5
`define PIN0_DIR_BIT        4
`define PIN2_SRC_BIT        3
`define PIN2_LEVEL_BIT      2
`define PIN1_LEVEL_BIT      1
`define PIN0_LEVEL_BIT      0
`define PIN_DIR_BASE        4

// command byte: opcode in [7:4], register address in [3:1]
`define CMD_WRITE_OP        4'h4
`define CMD_READ_OP         4'h2
`define CMD_OP_HI           7
`define CMD_OP_LO           4
`define CMD_ADDR_HI         3
`define CMD_ADDR_LO         1

// synchronisation word (alternating bits, four falling edges after start)
`define SYNC_WORD           8'h55
`define SYNC_FALL_EDGES     3'h4
`define SYNC_BIT_SHIFT      3

// answer for an address this block does not hold
`define UNMAPPED_READ       8'h00

`endif

// ### rtl/uart_autobaud_rx.v
// uart receiver that learns its bit period from the synchronisation word
`timescale 1ns/1ps
`default_nettype none
`include "adc_gpio_config_map.vh"

module uart_autobaud_rx #(
	parameter CNT_W = 20                  // width of the bit-time counters
) (
	input  wire             sys_clk,      // system clock
	input  wire             rst,          // synchronous reset, active high
	input  wire             rx,           // receive line, already synchronised
	input  wire             hunt,         // next frame is a sync word
	output reg              sync_ok_q,    // one-cycle pulse: sync word measured
	output reg              byte_valid_q, // one-cycle pulse: byte received
	output reg  [7:0]       byte_q,       // received byte
	output reg  [CNT_W-1:0] period_q      // learned bit period in clocks
);

	localparam [1:0] S_IDLE = 2'd0;       // wait for a start bit
	localparam [1:0] S_MEAS = 2'd1;       // timing the sync word
	localparam [1:0] S_DATA = 2'd2;       // sampling a data frame
	// full-width step keeps the counter sums the width of the counter
	localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

	reg [1:0]       state_q;              // receiver state
	reg             rx_prev_q;            // last line level for edge detect
	reg [CNT_W-1:0] cnt_q;                // clocks since last reference point
	reg [2:0]       edges_q;              // falling edges seen in the sync word
	reg [3:0]       bit_q;                // 0 start, 1..8 data, 9 stop
	reg [7:0]       shift_q;              // data assembly, lsb first
	wire            fall;                 // falling edge on the line
	wire [CNT_W-1:0] target;              // sample point for the current bit

	assign fall   = rx_prev_q & ~rx;
	// start bit is checked in its middle, every later bit one period on
	assign target = (bit_q == 4'd0) ? {1'b0, period_q[CNT_W-1:1]} : period_q;

	// frame timing and sampling
	always @(posedge sys_clk) begin
		if (rst) begin
			state_q      <= S_IDLE;
			rx_prev_q    <= 1'b1;
			cnt_q        <= {CNT_W{1'b0}};
			edges_q      <= 3'd0;
			bit_q        <= 4'd0;
			shift_q      <= 8'h00;
			sync_ok_q    <= 1'b0;
			byte_valid_q <= 1'b0;
			byte_q       <= 8'h00;
			period_q     <= {CNT_W{1'b1}};
		end else begin
			rx_prev_q    <= rx;
			sync_ok_q    <= 1'b0;
			byte_valid_q <= 1'b0;
			case (state_q)
			S_IDLE: begin
				cnt_q   <= {{(CNT_W-1){1'b0}}, 1'b1};
				edges_q <= 3'd0;
				bit_q   <= 4'd0;
				if (fall) begin
					// baud is learned from the sync word only
					state_q <= hunt ? S_MEAS : S_DATA;
				end
			end
			S_MEAS: begin
				cnt_q <= cnt_q + CNT_ONE;
				if (&cnt_q) begin
					// line too slow to be a sync word: give up
					state_q <= S_IDLE;
				end else if (fall) begin
					edges_q <= edges_q + 3'd1;
					if (edges_q + 3'd1 == `SYNC_FALL_EDGES) begin
						// eight bit times span start to the last falling edge
						period_q  <= cnt_q >> `SYNC_BIT_SHIFT;
						sync_ok_q <= 1'b1;
						state_q   <= S_IDLE;
					end
				end
			end
			S_DATA: begin
				cnt_q <= cnt_q + CNT_ONE;
				if (cnt_q >= target) begin
					cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1};
					bit_q <= bit_q + 4'd1;
					if (bit_q == 4'd0) begin
						// glitch rather than start bit
						if (rx) begin
							state_q <= S_IDLE;
						end
					end else if (bit_q == 4'd9) begin
						// framing error drops the byte silently
						byte_valid_q <= rx;
						byte_q       <= shift_q;
						state_q      <= S_IDLE;
					end else begin
						shift_q <= {rx, shift_q[7:1]};
					end
				end
			end
			default: begin
				state_q <= S_IDLE;
			end
			endcase
		end
	end

endmodule
`default_nettype wire

// ### rtl/adc_gpio_config_port.v
// three general-purpose pins behind a uart-reached configuration register
//
// Behaviour
// - bit 7 reserved, reads zero, write zero
// - bit 6 sets pin 2 direction
// - bit 5 sets pin 1 direction
// - bit 4 sets pin 0 direction
// - bit 3 picks pin 2 level or ready
// - bit 2 drives or senses pin 2
// - bit 1 drives or senses pin 1
// - bit 0 drives or senses pin 0
// - register at address 04h, resets to 00h
// - sync word precedes each command, sets baud
// - ready drives shared pin low
`timescale 1ns/1ps
`default_nettype none
`include "adc_gpio_config_map.vh"

module adc_gpio_config_port #(
	parameter CNT_W = 20                  // bit-time counter width
) (
	input  wire       sys_clk,            // system clock, 100 MHz
	input  wire       rst,                // synchronous reset, active high
	input  wire       uart_rx,            // command line from the host
	output reg        uart_tx,            // answer line to the host
	input  wire       conversion_ready,   // high while a new result waits
	input  wire [2:0] pin_in,             // sensed pin levels
	output reg  [2:0] pin_out,            // driven pin levels
	output reg  [2:0] pin_oe              // high while a pin is driven
);

	localparam [1:0] M_SYNC = 2'd0;       // waiting for the sync word
	localparam [1:0] M_CMD  = 2'd1;       // waiting for the command byte
	localparam [1:0] M_DATA = 2'd2;       // waiting for write data
	localparam [1:0] M_SEND = 2'd3;       // shifting out a read answer
	localparam [CNT_W-1:0] TX_ONE = {{(CNT_W-1){1'b0}}, 1'b1}; // tx step

	reg  [1:0]       mode_q;              // command state
	reg  [6:0]       cfg_q;               // register bits 6..0
	reg              rx_meta_q;           // rx synchroniser, first stage
	reg              rx_sync_q;           // rx synchroniser, second stage
	reg  [2:0]       pin_meta_q;          // pin synchroniser, first stage
	reg  [2:0]       pin_sync_q;          // pin synchroniser, second stage
	reg  [2:0]       addr_q;              // address of a pending write
	reg  [9:0]       tx_shift_q;          // stop, data, start; lsb out first
	reg  [3:0]       tx_bits_q;           // bits still to send
	reg  [CNT_W-1:0] tx_cnt_q;            // clocks into the current tx bit
	wire             sync_ok;             // sync word measured
	wire             byte_valid;          // a byte arrived
	wire [7:0]       rx_byte;             // the byte that arrived
	wire [CNT_W-1:0] period;              // learned bit period
	wire [3:0]       opcode;              // command opcode field
	wire [2:0]       cmd_addr;            // command address field
	integer          i;                   // pin loop index

	assign opcode   = rx_byte[`CMD_OP_HI:`CMD_OP_LO];
	assign cmd_addr = rx_byte[`CMD_ADDR_HI:`CMD_ADDR_LO];

	// read answer; bit 7 is always zero and other addresses read as zero
	function [7:0] read_value;
		input [2:0] addr;
		input [6:0] cfg;
		begin
			if (addr == `PIN_CFG_ADDR) begin
				read_value = {1'b0, cfg};
			end else begin
				read_value = `UNMAPPED_READ;
			end
		end
	endfunction

	// two flops on uart_rx and pin_in before any logic looks at them; conversion_ready is not synchronised
	always @(posedge sys_clk) begin
		if (rst) begin
			rx_meta_q  <= 1'b1;
			rx_sync_q  <= 1'b1;
			pin_meta_q <= 3'b000;
			pin_sync_q <= 3'b000;
		end else begin
			rx_meta_q  <= uart_rx;
			rx_sync_q  <= rx_meta_q;
			pin_meta_q <= pin_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	uart_autobaud_rx #(
		.CNT_W        (CNT_W)
	) u_rx (
		.sys_clk      (sys_clk),
		.rst          (rst),
		.rx           (rx_sync_q),
		.hunt         (mode_q == M_SYNC),
		.sync_ok_q    (sync_ok),
		.byte_valid_q (byte_valid),
		.byte_q       (rx_byte),
		.period_q     (period)
	);

	// command sequencing, register storage and the answer shifter
	always @(posedge sys_clk) begin
		if (rst) begin
			mode_q     <= M_SYNC;
			cfg_q      <= `PIN_CFG_RESET;
			addr_q     <= 3'h0;
			tx_shift_q <= 10'h3ff;
			tx_bits_q  <= 4'd0;
			tx_cnt_q   <= {CNT_W{1'b0}};
		end else begin
			// input pins keep tracking the sensed level into their level bit
			for (i = 0; i < 3; i = i + 1) begin
				if (!cfg_q[`PIN_DIR_BASE + i]) begin
					cfg_q[i] <= pin_sync_q[i];
				end
			end
			case (mode_q)
			M_SYNC: begin
				// every command needs a fresh sync word first
				if (sync_ok) begin
					mode_q <= M_CMD;
				end
			end
			M_CMD: begin
				if (byte_valid) begin
					addr_q <= cmd_addr;
					if (opcode == `CMD_WRITE_OP) begin
						mode_q <= M_DATA;
					end else if (opcode == `CMD_READ_OP) begin
						tx_shift_q <= {1'b1, read_value(cmd_addr, cfg_q), 1'b0};
						tx_bits_q  <= 4'd10;
						tx_cnt_q   <= {CNT_W{1'b0}};
						mode_q     <= M_SEND;
					end else begin
						// anything else belongs to other logic; resync
						mode_q <= M_SYNC;
					end
				end
			end
			M_DATA: begin
				if (byte_valid) begin
					if (addr_q == `PIN_CFG_ADDR) begin
						// reserved bit 7 of the data is dropped
						cfg_q <= rx_byte[6:0];
					end
					mode_q <= M_SYNC;
				end
			end
			M_SEND: begin
				// the answer uses the baud learned from the last sync word
				if (tx_cnt_q + TX_ONE >= period) begin
					tx_cnt_q   <= {CNT_W{1'b0}};
					tx_shift_q <= {1'b1, tx_shift_q[9:1]};
					tx_bits_q  <= tx_bits_q - 4'd1;
					if (tx_bits_q == 4'd1) begin
						mode_q <= M_SYNC;
					end
				end else begin
					tx_cnt_q <= tx_cnt_q + TX_ONE;
				end
			end
			default: begin
				mode_q <= M_SYNC;
			end
			endcase
		end
	end

	// pin drivers and tx line, all straight from flops
	always @(posedge sys_clk) begin
		if (rst) begin
			uart_tx <= 1'b1;
			pin_out <= 3'b000;
			pin_oe  <= 3'b000;
		end else begin
			uart_tx <= (mode_q == M_SEND) ? tx_shift_q[0] : 1'b1;
			// an input pin has its enable low, so the source bit is moot
			pin_oe[2]  <= cfg_q[`PIN2_DIR_BIT];
			pin_oe[1]  <= cfg_q[`PIN1_DIR_BIT];
			pin_oe[0]  <= cfg_q[`PIN0_DIR_BIT];
			pin_out[1] <= cfg_q[`PIN1_LEVEL_BIT];
			pin_out[0] <= cfg_q[`PIN0_LEVEL_BIT];
			if (cfg_q[`PIN2_SRC_BIT]) begin
				// ready is shown active low on the shared pin
				pin_out[2] <= ~conversion_ready;
			end else begin
				pin_out[2] <= cfg_q[`PIN2_LEVEL_BIT];
			end
		end
	end

endmodule
`default_nettype wire

// ### verification/adc_gpio_config_port_assertions.sv
// checker watching the pin configuration port from its ports
`timescale 1ns/1ps
`default_nettype none
module adc_gpio_cfg_chk #(
	parameter CNT_W = 20                   // bit-time counter width
) (
	input wire logic       sys_clk,        // system clock
	input wire logic       rst,            // synchronous reset
	input wire logic       uart_rx,        // host command line
	input wire logic       uart_tx,        // answer line
	input wire logic       conversion_ready, // new result flag
	input wire logic [2:0] pin_in,         // sensed levels
	input wire logic [2:0] pin_out,        // driven levels
	input wire logic [2:0] pin_oe          // drive enables
);
	// enables and driven pin 0 and 1 levels may only move shortly after host traffic; the limit assumes
	// the bench bit period of 16 clocks, a limitation of this checker
	localparam int QUIET = 40;
	logic [7:0] quiet_q;                   // clocks since line was low
	always_ff @(posedge sys_clk) begin
		if (rst || !uart_rx)
			quiet_q <= 8'h00;
		else if (quiet_q != 8'hff)
			quiet_q <= quiet_q + 8'h01;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_reset_pins_off: assert property (
		$fell(rst) |-> pin_oe == 3'h0 && pin_out == 3'h0)
		else $error("pins active after reset");
	a_reset_tx_idle: assert property (
		$fell(rst) |-> uart_tx == 1'b1) else $error("answer line not idle");
	a_dir_hold: assert property (
		$changed(pin_oe) |=> $stable(pin_oe) [*8])
		else $error("drive enables unsettled");
	a_dir_cause: assert property (
		$changed(pin_oe) |-> quiet_q < QUIET)
		else $error("drive enable moved without a write");
	a_level_cause: assert property (
		$changed(pin_out[1:0] & pin_oe[1:0]) |-> quiet_q < QUIET)
		else $error("driven level moved without a write");
	a_ready_follow: assert property (
		pin_oe[2] && $stable(pin_oe[2]) && $changed(pin_out[2])
		&& quiet_q >= QUIET |-> pin_out[2] == !$past(conversion_ready))
		else $error("shared pin does not show inverted ready");
	a_tx_low_bit: assert property (
		$fell(uart_tx) |-> !uart_tx [*8]) else $error("short low bit");
	a_tx_high_bit: assert property (
		$rose(uart_tx) |-> uart_tx [*8]) else $error("short high bit");
	c_all_out: cover property (pin_oe == 3'h7);
	c_answer: cover property ($fell(uart_tx));
	c_ready_pin: cover property (pin_oe[2] && $changed(pin_out[2])
		&& quiet_q >= QUIET);
	c_input_high: cover property (!pin_oe[0] && pin_in[0]);
endmodule
bind adc_gpio_config_port adc_gpio_cfg_chk #(.CNT_W(CNT_W)) chk (
	.sys_clk(sys_clk), .rst(rst), .uart_rx(uart_rx), .uart_tx(uart_tx),
	.conversion_ready(conversion_ready), .pin_in(pin_in),
	.pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// ### verification/host_uart_model.sv
// host side model: framed commands out, answers in
`timescale 1ns/1ps
`default_nettype none
`include "adc_gpio_config_map.vh"
module host_uart_model #(
	parameter int P = 16          // bit period in clocks
) (
	input wire logic sys_clk,     // system clock
	output logic     tx,          // line into the device
	input wire logic rx           // answer line from the device
);
	initial tx = 1'b1;            // line idles high
	// one 8-N-1 frame lsb first; a short stop lets a read catch an
	// answer that starts before a full stop bit has passed
	task automatic send(input logic [7:0] b, input int stop);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			tx <= f[i];
			repeat (i == 9 ? stop : P) @(posedge sys_clk);
		end
	endtask
	// every command gets a fresh sync word so the rate is relearned
	task automatic cmd(input logic [7:0] c, input int stop);
		send(`SYNC_WORD, P);
		send(c, stop);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		cmd({`CMD_WRITE_OP, a, 1'b0}, P);
		send({1'b0, d[6:0]}, P);
	endtask
	// unknown is returned if no answer comes or its stop bit is low
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		int n;
		d = 8'hxx;
		n = 0;
		cmd({`CMD_READ_OP, a, 1'b0}, P / 2);
		while (rx !== 1'b0 && n < 4 * P) begin
			@(posedge sys_clk);
			n++;
		end
		if (n < 4 * P) begin
			repeat (P / 2) @(posedge sys_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (P) @(posedge sys_clk);
				d[i] = rx;
			end
			repeat (P) @(posedge sys_clk);
			if (rx !== 1'b1)
				d = 8'hxx;
			repeat (P) @(posedge sys_clk); // answer over before next
		end
	endtask
endmodule
`default_nettype wire

// ### verification/adc_gpio_config_port_tb.sv
// self-checking bench for the pin configuration port
`timescale 1ns/1ps
`default_nettype none
`include "adc_gpio_config_map.vh"
module adc_gpio_config_port_tb;
	localparam logic [6:0] CORNER [4] = '{7'h7f, 7'h48, 7'h08, 7'h37};
	logic       sys_clk;          // 100 MHz clock
	logic       rst;              // synchronous reset
	logic       host_tx;          // host to device line
	logic       dev_tx;           // device to host line
	logic       rdy_q;            // conversion-ready level
	logic [2:0] ext_q;            // levels from the outside world
	logic [2:0] pin_in;           // resolved pin levels
	logic [2:0] pin_out;          // levels the device drives
	logic [2:0] pin_oe;           // device drive enables
	logic [7:0] got;              // register read back
	logic [6:0] cfg;              // value last written
	int         err_total;        // mismatches
	int         samples_checked;  // comparisons made
	// a driven pin shows the device level, otherwise the outside one
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_q);
	adc_gpio_config_port #(.CNT_W(16)) dut (
		.sys_clk(sys_clk), .rst(rst), .uart_rx(host_tx), .uart_tx(dev_tx),
		.conversion_ready(rdy_q), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe));
	host_uart_model #(.P(16)) host (
		.sys_clk(sys_clk), .tx(host_tx), .rx(dev_tx));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
			err_total++;
		end
	endtask
	// input pins report what the outside world puts on them
	function automatic logic [7:0] reg_x(input logic [6:0] d,
		input logic [2:0] e);
		return {1'b0, d[6:3], (d[6:4] & d[2:0]) | (~d[6:4] & e)};
	endfunction
	// pin 2 carries the inverted ready flag when its source is picked
	function automatic logic [2:0] pins_x(input logic [6:0] d,
		input logic r);
		return {d[3] ? ~r : d[2], d[1:0]} & d[6:4];
	endfunction
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// the run needs about 20k cycles; far past that something hangs
	initial begin
		repeat (60000) @(posedge sys_clk);
		err_total++;
		test_done;
	end
	initial begin
		rst = 1'b1;
		rdy_q = 1'b0;
		ext_q = 3'h0;
		err_total = 0;
		samples_checked = 0;
		void'($urandom(50));
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk({pin_oe, pin_out, 1'b1, dev_tx}, 8'h03);
		host.rd(`PIN_CFG_ADDR, got);
		chk(got, 8'h00);
		// corner values first, then random ones, each read back
		for (int i = 0; i < 14; i++) begin
			cfg = i < 4 ? CORNER[i] : 7'($urandom);
			ext_q <= 3'($urandom);
			rdy_q <= 1'($urandom);
			host.wr(`PIN_CFG_ADDR, {1'b0, cfg});
			repeat (40) @(posedge sys_clk);
			chk(8'(pin_oe), 8'(cfg[6:4]));
			chk(8'(pin_out & pin_oe), 8'(pins_x(cfg, rdy_q)));
			rdy_q <= ~rdy_q;
			repeat (4) @(posedge sys_clk);
			chk(8'(pin_out & pin_oe), 8'(pins_x(cfg, rdy_q)));
			host.rd(`PIN_CFG_ADDR, got);
			chk(got, reg_x(cfg, ext_q));
		end
		// writes and reads elsewhere leave the register alone
		host.wr(3'h5, 8'h7f);
		host.rd(`PIN_CFG_ADDR, got);
		chk(got, reg_x(cfg, ext_q));
		host.rd(3'h3, got);
		chk(got, `UNMAPPED_READ);
		// an opcode this block does not own ends the command untouched
		host.cmd(8'h60, 16);
		host.rd(`PIN_CFG_ADDR, got);
		chk(got, reg_x(cfg, ext_q));
		// a reset in mid-run returns every pin to input
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		host.rd(`PIN_CFG_ADDR, got);
		chk(got, reg_x(7'h00, ext_q));
		test_done;
	end
endmodule
`default_nettype wire
